// File: logic/boot_mode_pkg.sv
// Constants, types and carriers shared by the boot configuration decoder.
// Assumes a 16-bit flash read port and a classic Wishbone register bus.
package boot_mode_pkg;

  // ************************************************************
  // Configuration codes and flash locations
  // ************************************************************
  localparam logic [1:0]  CFG_NORMAL = 2'h3;
  localparam logic [1:0]  CFG_STD    = 2'h2;
  localparam logic [1:0]  CFG_ALT    = 2'h1;
  localparam logic [23:0] ALT_OP0    = 24'h090000;
  localparam logic [23:0] ALT_OP1    = 24'h091FFC;
  localparam logic [23:0] ALT_REF    = 24'h091FFE;
  localparam logic [23:0] USR_OP0    = 24'h000000;
  localparam logic [23:0] USR_OP1    = 24'h001FFC;
  localparam logic [23:0] USR_REF    = 24'h001FFE;
  localparam logic [15:0] SEL_ZERO   = 16'h0000;
  localparam logic [15:0] SEL_ONES   = 16'hFFFF;
  localparam logic [7:0]  CH_UART    = 8'h01;
  localparam logic [7:0]  CH_CAN     = 8'h02;
  localparam logic [7:0]  CH_BOTH    = 8'h03;
  localparam logic [2:0]  IDX_SEL    = 3'h6;
  localparam int          UART_BIT   = 0;
  localparam int          CAN_BIT    = 1;
  localparam int          FLAG_BIT   = 5;

  // ************************************************************
  // Register map (byte offsets) and reset values
  // ************************************************************
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_MODE   = 4'h4;
  localparam logic [3:0]  REG_CHAN   = 4'h8;
  localparam logic [3:0]  REG_CTRL   = 4'hC;
  localparam logic [1:0]  CTRL_RESET = 2'h3;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_NORMAL, MODE_STD, MODE_ALT_USER,
    MODE_USER, MODE_SEL, MODE_LOOP, MODE_TEST
  } boot_mode_t;

  typedef enum {st_hold, st_decode, st_read, st_done} seq_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } flash_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] data;
  } flash_rsp_t;

  function automatic logic [23:0] addr_of(input logic [2:0] idx);
    case (idx)
      3'h0:    addr_of = ALT_OP0;
      3'h1:    addr_of = ALT_OP1;
      3'h2:    addr_of = ALT_REF;
      3'h3:    addr_of = USR_OP0;
      3'h4:    addr_of = USR_OP1;
      3'h5:    addr_of = USR_REF;
      default: addr_of = USR_OP1;
    endcase
  endfunction

endpackage

// File: logic/boot_mode_select.sv
// Boot configuration decoder with flash signature check and selective boot.
// Assumes pins come from outside (synchronised here); flash port and bus on clk.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
module boot_mode_select
  import boot_mode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reset_input_pin_n,
  input  wire logic [1:0] config_port_low,
  input  wire wb_req_t    wb_i,
  output wb_rsp_t         wb_o,
  output flash_req_t      flash_o,
  input  wire flash_rsp_t flash_i,
  output boot_mode_t      boot_mode,
  output logic            alt_boot_flag,
  output logic            watch_uart,
  output logic            watch_can,
  output logic            boot_done
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic       pin_s1, pin_s2, pin_prev;
  logic [1:0] cfg_s1, cfg_s2;
  logic       pin_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1   <= 1'b0;
      pin_s2   <= 1'b0;
      pin_prev <= 1'b0;
      cfg_s1   <= 2'h0;
      cfg_s2   <= 2'h0;
    end else begin
      pin_s1   <= reset_input_pin_n;
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
      cfg_s1   <= config_port_low;
      cfg_s2   <= cfg_s1;
    end
  end

  assign pin_rise = pin_s2 & ~pin_prev;

  // ************************************************************
  // Boot sequencer
  // ************************************************************
  seq_state_t state, next_state;
  boot_mode_t mode, next_mode;
  logic       flag, next_flag;
  logic [7:0] chan, next_chan;
  logic [2:0] idx, next_idx;
  logic [1:0] cfg_cap, next_cfg;
  logic [15:0] op0, next_op0, op1, next_op1;
  logic       freq, next_req;
  logic [23:0] faddr, next_addr;
  logic [15:0] sig_sum;
  logic       sig_ok;
  logic       sel_blank;

  assign sig_sum   = 16'(op0 + op1);
  assign sig_ok    = ((~sig_sum) == flash_i.data);
  assign sel_blank = (flash_i.data == SEL_ZERO) || (flash_i.data == SEL_ONES);

  always_comb begin
    next_state = state;
    next_mode  = mode;
    next_flag  = flag;
    next_chan  = chan;
    next_idx   = idx;
    next_cfg   = cfg_cap;
    next_op0   = op0;
    next_op1   = op1;
    next_req   = freq;
    next_addr  = faddr;
    case (state)
      st_hold: begin
        if (pin_rise) begin
          next_cfg   = cfg_s2;
          next_state = st_decode;
        end
      end
      st_decode: begin
        next_state = st_done;
        case (cfg_cap)
          CFG_NORMAL: next_mode = MODE_NORMAL;
          CFG_STD: begin
            next_mode = MODE_STD;
            next_flag = 1'b0;
          end
          CFG_ALT: begin
            next_flag  = 1'b1;
            next_idx   = 3'h0;
            next_state = st_read;
          end
          default: next_mode = MODE_TEST;
        endcase
      end
      st_read: begin
        if (!freq) begin
          next_req  = 1'b1;
          next_addr = addr_of(idx);
        end else if (flash_i.ack) begin
          next_req = 1'b0;
          next_idx = 3'(idx + 3'h1);
          case (idx)
            3'h0, 3'h3: next_op0 = flash_i.data;
            3'h1, 3'h4: next_op1 = flash_i.data;
            3'h2, 3'h5: begin
              if (sig_ok) begin
                next_mode  = (idx == 3'h2) ? MODE_ALT_USER : MODE_USER;
                next_state = st_done;
              end
            end
            default: begin
              next_state = st_done;
              if (sel_blank) begin
                next_mode = MODE_STD;
              end else begin
                next_chan = flash_i.data[7:0];
                case (flash_i.data[7:0])
                  CH_UART, CH_CAN, CH_BOTH: next_mode = MODE_SEL;
                  default: next_mode = MODE_LOOP;
                endcase
              end
            end
          endcase
        end
      end
      st_done: next_state = st_done;
      default: next_state = st_hold;
    endcase
    // Pin held low is a hardware reset of everything decoded so far
    if (!pin_s2) begin
      next_state = st_hold;
      next_mode  = MODE_NONE;
      next_flag  = 1'b0;
      next_chan  = 8'h00;
      next_idx   = 3'h0;
      next_req   = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= st_hold;
      mode    <= MODE_NONE;
      flag    <= 1'b0;
      chan    <= 8'h00;
      idx     <= 3'h0;
      cfg_cap <= 2'h0;
      op0     <= 16'h0000;
      op1     <= 16'h0000;
      freq    <= 1'b0;
      faddr   <= 24'h000000;
    end else begin
      state   <= next_state;
      mode    <= next_mode;
      flag    <= next_flag;
      chan    <= next_chan;
      idx     <= next_idx;
      cfg_cap <= next_cfg;
      op0     <= next_op0;
      op1     <= next_op1;
      freq    <= next_req;
      faddr   <= next_addr;
    end
  end

  assign flash_o.req   = freq;
  assign flash_o.addr  = faddr;
  assign boot_mode     = mode;
  assign alt_boot_flag = flag;
  assign boot_done     = (state == st_done);

  // ************************************************************
  // Wishbone slave and channel gating
  // ************************************************************
  // Software may only mask a watched line, never enable one the word left off
  logic [1:0]  ctrl, next_ctrl;
  logic        ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic        wu, next_wu, wc, next_wc;
  logic        hit;

  assign hit = wb_i.cyc & wb_i.stb;

  always_comb begin
    next_ctrl = ctrl;
    next_ack  = hit & ~ack;
    next_rdat = rdat;
    if (hit & ack & wb_i.we & wb_i.sel[0] & (wb_i.adr[3:0] == REG_CTRL)) begin
      next_ctrl = wb_i.dat[1:0];
    end
    if (hit & ~ack) begin
      case (wb_i.adr[3:0])
        REG_STATUS: next_rdat = {26'h0, flag, 2'h0, wc, wu, boot_done};
        REG_MODE:   next_rdat = {29'h0, mode};
        REG_CHAN:   next_rdat = {24'h0, chan};
        REG_CTRL:   next_rdat = {30'h0, ctrl};
        default:    next_rdat = 32'h0;
      endcase
    end
    next_wu = (mode == MODE_SEL) & chan[UART_BIT] & ctrl[UART_BIT];
    next_wc = (mode == MODE_SEL) & chan[CAN_BIT] & ctrl[CAN_BIT];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      ack  <= 1'b0;
      rdat <= 32'h0;
      wu   <= 1'b0;
      wc   <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ack  <= next_ack;
      rdat <= next_rdat;
      wu   <= next_wu;
      wc   <= next_wc;
    end
  end

  assign wb_o.ack   = ack;
  assign wb_o.dat   = rdat;
  assign watch_uart = wu;
  assign watch_can  = wc;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_capture;
    @(posedge clk) disable iff (rst)
    (state == st_hold && pin_rise) |=> (cfg_cap == $past(cfg_s2)) && (state == st_decode);
  endproperty
  a_capture: assert property (p_capture) else $error("config not captured on pin rise");

  property p_normal;
    @(posedge clk) disable iff (rst)
    (state == st_decode && cfg_cap == CFG_NORMAL && pin_s2) |=> (mode == MODE_NORMAL) && boot_done;
  endproperty
  a_normal: assert property (p_normal) else $error("normal start not chosen");

  property p_std;
    @(posedge clk) disable iff (rst)
    (state == st_decode && cfg_cap == CFG_STD && pin_s2) |=> (mode == MODE_STD) && !flag;
  endproperty
  a_std: assert property (p_std) else $error("standard loader not chosen");

  property p_alt;
    @(posedge clk) disable iff (rst)
    (state == st_decode && cfg_cap == CFG_ALT && pin_s2) ##1 pin_s2
      |-> flag ##1 (flash_o.req && flash_o.addr == ALT_OP0);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate boot did not start check");

  property p_test;
    @(posedge clk) disable iff (rst)
    (state == st_decode && cfg_cap == 2'h0 && pin_s2) |=> (mode == MODE_TEST);
  endproperty
  a_test: assert property (p_test) else $error("test mode not chosen");

  property p_reread;
    @(posedge clk) disable iff (rst)
    (flash_o.req && idx == IDX_SEL) |-> (flash_o.addr == USR_OP1);
  endproperty
  a_reread: assert property (p_reread) else $error("wrong re-read address");

  property p_blank;
    @(posedge clk) disable iff (rst)
    (state == st_read && freq && flash_i.ack && idx == IDX_SEL && sel_blank && pin_s2)
      |=> (mode == MODE_STD) && boot_done;
  endproperty
  a_blank: assert property (p_blank) else $error("blank word not sent to loader");

  property p_loop;
    @(posedge clk) disable iff (rst)
    (state == st_read && freq && flash_i.ack && idx == IDX_SEL && !sel_blank && pin_s2
      && flash_i.data[7:0] > CH_BOTH) |=> (mode == MODE_LOOP) && (chan == $past(flash_i.data[7:0]));
  endproperty
  a_loop: assert property (p_loop) else $error("undefined word did not loop");

  property p_sig;
    @(posedge clk) disable iff (rst)
    (state == st_read && freq && flash_i.ack && idx == 3'h2 && sig_ok && pin_s2)
      |=> (mode == MODE_ALT_USER);
  endproperty
  a_sig: assert property (p_sig) else $error("matching signature ignored");

  property p_flag;
    @(posedge clk) disable iff (rst)
    (flag && pin_s2) |=> flag;
  endproperty
  a_flag: assert property (p_flag) else $error("alternate flag lost before reset");

  property p_watch;
    @(posedge clk) disable iff (rst)
    (mode == MODE_SEL) |=> (watch_uart == $past(chan[UART_BIT] & ctrl[UART_BIT]))
      && (watch_can == $past(chan[CAN_BIT] & ctrl[CAN_BIT]));
  endproperty
  a_watch: assert property (p_watch) else $error("watched lines disagree with word");

  property p_hold;
    @(posedge clk) disable iff (rst)
    (state == st_done && pin_s2) |=> $stable(mode) && $stable(chan);
  endproperty
  a_hold: assert property (p_hold) else $error("decoded mode changed before reset");

endmodule

// File: testbench/flash_model.sv
// Flash stand-in answering the decoder's word reads, promptly or slowly.
// Assumes one read at a time, held until ack, on the decoder's clock.
`timescale 1ns/100ps
module flash_model
  import boot_mode_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire flash_req_t       flash_o,
  input  wire logic [5:0][15:0] words,
  input  wire logic [2:0]       slow,
  output flash_rsp_t            flash_i
);
  // ************************************************************
  // Read answer
  // ************************************************************
  logic [2:0] cnt;
  function automatic logic [15:0] lookup(input logic [23:0] a);
    case (a)
      ALT_OP0: lookup = words[0];
      ALT_OP1: lookup = words[1];
      ALT_REF: lookup = words[2];
      USR_OP0: lookup = words[3];
      USR_OP1: lookup = words[4];
      USR_REF: lookup = words[5];
      default: lookup = ~words[0];
    endcase
  endfunction
  // Data toggles while idle so a stale word is never mistaken for a read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_i <= '0;
      cnt     <= 3'h0;
    end else if (flash_i.ack) begin
      flash_i.ack  <= 1'b0;
      flash_i.data <= ~flash_i.data;
    end else if (flash_o.req && cnt >= slow) begin
      flash_i.ack  <= 1'b1;
      flash_i.data <= lookup(flash_o.addr);
      cnt          <= 3'h0;
    end else begin
      flash_i.data <= ~flash_i.data;
      cnt          <= flash_o.req ? cnt + 3'h1 : 3'h0;
    end
  end
endmodule

// File: testbench/boot_mode_select_bench.sv
// Self-checking bench for the boot configuration decoder.
// Assumes the flash model on the far side and a Wishbone register view.
`timescale 1ns/100ps
module boot_mode_select_bench
  import boot_mode_pkg::*;
;
  // ************************************************************
  // Stimulus and checking
  // ************************************************************
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             pin_n = 1'b0;
  logic [1:0]       cfg = 2'h3;
  wb_req_t          wb_i = '0;
  wb_rsp_t          wb_o;
  flash_req_t       flash_o;
  flash_rsp_t       flash_i;
  boot_mode_t       boot_mode;
  logic             alt_boot_flag;
  logic             watch_uart;
  logic             watch_can;
  logic             boot_done;
  logic [5:0][15:0] words = '0;
  logic [2:0]       slow = 3'h0;
  int               errors = 0;
  int               cmp_count = 0;
  int               cycles = 0;
  int               seed = 32'h33c7;

  boot_mode_select dut (.clk(clk), .rst(rst), .reset_input_pin_n(pin_n), .config_port_low(cfg),
    .wb_i(wb_i), .wb_o(wb_o), .flash_o(flash_o), .flash_i(flash_i), .boot_mode(boot_mode),
    .alt_boot_flag(alt_boot_flag), .watch_uart(watch_uart), .watch_can(watch_can),
    .boot_done(boot_done));
  flash_model mem (.clk(clk), .rst(rst), .flash_o(flash_o), .words(words), .slow(slow),
    .flash_i(flash_i));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard: a run of eleven boots needs far fewer cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: {28'h0, a}, dat: d};
    do @(posedge clk); while (wb_o.ack !== 1'b1);
    q = wb_o.dat;
    wb_i <= '0;
  endtask

  task automatic run_case(input int k);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] s;
    logic [1:0]  code;
    logic [31:0] rd;
    logic [1:0]  msk;
    int          m;
    int          u;
    int          c;
    a = 16'($random(seed));
    b = 16'($random(seed));
    s = 16'($random(seed));
    code = (k == 0) ? 2'h3 : (k == 1) ? 2'h2 : (k == 2) ? 2'h0 : 2'h1;
    // Reserved low-byte bits stay zero in the valid channel words
    case (k)
      5: s = {s[15:8], 8'h01};
      6: s = {s[15:8], 8'h02};
      7: s = {s[15:8], 8'h03};
      8: s = 16'h0000;
      9: s = 16'hFFFF;
      10: s = {s[15:8], 8'h07};
      default: s = a;
    endcase
    words[0] <= a;
    words[1] <= b;
    words[2] <= (k == 3) ? ~(a + b) : a + b;
    words[3] <= b;
    words[4] <= s;
    words[5] <= (k == 4) ? ~(b + s) : b + s;
    if (code == 2'h3) m = MODE_NORMAL;
    else if (code == 2'h2) m = MODE_STD;
    else if (code == 2'h0) m = MODE_TEST;
    else if (k == 3) m = MODE_ALT_USER;
    else if (k == 4) m = MODE_USER;
    else if (s == 16'h0000 || s == 16'hFFFF) m = MODE_STD;
    else if (s[7:0] >= 8'h01 && s[7:0] <= 8'h03) m = MODE_SEL;
    else m = MODE_LOOP;
    u = (m == MODE_SEL) ? int'(s[0]) : 0;
    c = (m == MODE_SEL) ? int'(s[1]) : 0;
    @(posedge clk);
    cfg   <= code;
    slow  <= 3'($random(seed));
    pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    // Pin noise after capture must not move the decoded result
    cfg <= 2'($random(seed));
    do @(posedge clk); while (boot_done !== 1'b1);
    repeat (3) @(posedge clk);
    check("boot_mode", 32'(boot_mode), m);
    check("alt_boot_flag", 32'(alt_boot_flag), 32'(code == 2'h1));
    check("watch_uart", 32'(watch_uart), u);
    check("watch_can", 32'(watch_can), c);
    // Status is read-only: a write must leave every bit as it was
    wb(1'b1, REG_STATUS, 32'hFFFF_FFFF, rd);
    wb(1'b0, REG_STATUS, 32'h0, rd);
    check("status", rd, 32'h1 | (u << 1) | (c << 2) | (int'(code == 2'h1) << 5));
    wb(1'b0, REG_MODE, 32'h0, rd);
    check("mode_reg", rd, m);
    if (m == MODE_SEL || m == MODE_LOOP) begin
      wb(1'b0, REG_CHAN, 32'h0, rd);
      check("chan_reg", rd, {24'h0, s[7:0]});
    end
    if (m == MODE_SEL) begin
      // Control bits only mask lines the word selected, never enable others
      msk = 2'(k + 1);
      wb(1'b1, REG_CTRL, {30'h0, msk}, rd);
      repeat (2) @(posedge clk);
      check("uart_masked", 32'(watch_uart), u & int'(msk[0]));
      check("can_masked", 32'(watch_can), c & int'(msk[1]));
      wb(1'b1, REG_CTRL, 32'h3, rd);
    end
  endtask

  initial begin
    logic [31:0] rd;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0, rd);
    check("ctrl_reset", rd, 32'h3);
    wb(1'b1, REG_CTRL, 32'h0, rd);
    wb(1'b0, REG_CTRL, 32'h0, rd);
    check("ctrl_rw", rd, 32'h0);
    wb(1'b1, 4'h2, 32'hFFFF_FFFF, rd);
    wb(1'b0, 4'h2, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    wb(1'b1, REG_CTRL, 32'h3, rd);
    for (int k = 0; k < 11; k++) begin
      run_case(k);
    end
    report_and_stop();
  end
endmodule
